/* File: rtl/id_config_consts.svh */
// Offsets, field values, reset values and the register count of the identity register bank.
`ifndef ID_CONFIG_CONSTS_SVH
`define ID_CONFIG_CONSTS_SVH
`define OFS_EEPROM_SIGNATURE 8'h00
`define OFS_VENDOR_ID_LOW 8'h01
`define OFS_VENDOR_ID_HIGH 8'h02
`define OFS_PRODUCT_ID_LOW 8'h03
`define OFS_PRODUCT_ID_HIGH 8'h04
`define SIGNATURE_MATCH 8'h55
`define SIGNATURE_RESET 8'h00
// Identity defaults are arbitrary neutral values, not any maker's code.
`define VID_RESET 16'h0001
`define PID_RESET 16'h0001
`define USB2_PID_XOR 16'h0002
`define ID_WORD_ZERO 16'h0000
`define BYTE_ZERO 8'h00
`define REG_COUNT 5
`endif

/* File: rtl/id_config_pkg.sv */
// Types shared by the identity register bank.
package id_config_pkg;
  typedef enum logic [1:0] {
    LOAD_IDLE = 2'b00,
    LOAD_CHECK = 2'b01,
    LOAD_RUN = 2'b10
  } load_state_t;
  typedef enum logic [1:0] {
    MODE_NONE = 2'b00,
    MODE_EEPROM = 2'b01,
    MODE_SMBUS = 2'b10
  } cfg_mode_t;
endpackage

/* File: rtl/id_reg_if.sv */
// Byte write and read signals between the bank control and its byte store.
`timescale 1ns/1ps
`default_nettype none
interface id_reg_if;
  logic we;
  logic [7:0] waddr;
  logic [7:0] wdata;
  logic [7:0] raddr;
  logic [7:0] rdata;
  logic [39:0] all_bytes;
  modport ctrl (output we, output waddr, output wdata, output raddr,
                input rdata, input all_bytes);
  modport store (input we, input waddr, input wdata, input raddr,
                 output rdata, output all_bytes);
endinterface
`default_nettype wire

/* File: rtl/id_byte_store.sv */
// Five byte-wide configuration registers with registered read data.
`timescale 1ns/1ps
`default_nettype none
`include "id_config_consts.svh"
module id_byte_store (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Access
  id_reg_if.store bus
);
  typedef struct packed {
    logic [`REG_COUNT-1:0][7:0] mem;
    logic [7:0] rdata;
  } store_state_t;

  localparam logic [`REG_COUNT-1:0][7:0] DEFAULTS = {`PID_RESET, `VID_RESET,
                                                     `SIGNATURE_RESET};

  store_state_t st_r;
  store_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    for (int i = 0; i < `REG_COUNT; i++) begin
      if (bus.we && bus.waddr == 8'(i)) begin
        st_nxt.mem[i] = bus.wdata;
      end
    end
    st_nxt.rdata = `BYTE_ZERO;
    for (int i = 0; i < `REG_COUNT; i++) begin
      if (bus.raddr == 8'(i)) begin
        st_nxt.rdata = st_r.mem[i];
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= '{mem: DEFAULTS, rdata: `BYTE_ZERO};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign bus.rdata = st_r.rdata;
  assign bus.all_bytes = st_r.mem;
endmodule
`default_nettype wire

/* File: rtl/id_config_register_bank.sv */
// Identity configuration registers: signature check, ID override and descriptor IDs.
// Notes on behaviour
// [RULE1] During an EEPROM load the first byte must be 55h, otherwise the load stops and defaults stay.
// [RULE2] The signature register is an 8-bit read/write byte that resets to zero.
// [RULE3] The vendor ID low byte sits at offset 1h and the high byte at 2h, both writable.
// [RULE4] When both one-time vendor and product values are nonzero, reads return those values.
// [RULE5] The SuperSpeed product ID is the stored value; the USB 2.0 one is it XOR 0002h.
// [RULE6] The product ID low byte sits at offset 3h and the high byte at 4h, both writable.
// [RULE7] Registers are reached one byte at a time, start at defaults, and change only in EEPROM or SMBus mode.
// [RULE8] While the one-time override holds, writes to the ID registers are dropped silently.
`timescale 1ns/1ps
`default_nettype none
`include "id_config_consts.svh"
module id_config_register_bank
  import id_config_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Configuration mode, sampled by the core at reset release
  input wire logic eeprom_mode_i,
  input wire logic smbus_mode_i,
  // One-time-programmed identity values
  input wire logic [15:0] otp_vendor_id_i,
  input wire logic [15:0] otp_product_id_i,
  // EEPROM loader byte stream, first byte is the signature
  input wire logic load_start_i,
  input wire logic load_valid_i,
  input wire logic [7:0] load_data_i,
  input wire logic load_last_i,
  output logic load_busy_o,
  output logic load_abort_o,
  output logic load_done_o,
  // SMBus host byte access
  input wire logic host_wr_i,
  input wire logic host_rd_i,
  input wire logic [7:0] host_addr_i,
  input wire logic [7:0] host_wdata_i,
  output logic [7:0] host_rdata_o,
  output logic host_rvalid_o,
  // Identity values to the descriptor logic
  output logic [15:0] vendor_id_o,
  output logic [15:0] product_id_ss_o,
  output logic [15:0] product_id_usb2_o
);
  typedef struct packed {
    load_state_t load;
    cfg_mode_t mode;
    logic [7:0] load_addr;
    logic abort;
    logic done;
    logic rd_pend;
    logic [7:0] rd_addr;
    logic rvalid;
    logic [7:0] rdata;
    logic [15:0] vid;
    logic [15:0] pid_ss;
    logic [15:0] pid_u2;
  } bank_state_t;

  bank_state_t st_r;
  bank_state_t st_nxt;
  id_reg_if regs ();
  logic otp_force;
  logic is_id_addr;
  logic [15:0] vid_now;
  logic [15:0] pid_now;
  logic [7:0] read_byte;
  logic [7:0] wr_addr;
  logic wr_req;

  id_byte_store store (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .bus(regs)
  );

  // Inputs come from core logic on this clock, so no synchronisers are used.
  assign otp_force = (otp_vendor_id_i != `ID_WORD_ZERO) &&
                     (otp_product_id_i != `ID_WORD_ZERO); // [RULE4]
  assign vid_now = otp_force ? otp_vendor_id_i : regs.all_bytes[23:8]; // [RULE3] [RULE4]
  assign pid_now = otp_force ? otp_product_id_i : regs.all_bytes[39:24]; // [RULE6] [RULE4]

  always_comb begin
    st_nxt = st_r;
    wr_req = 1'b0;
    wr_addr = `BYTE_ZERO;
    st_nxt.abort = 1'b0;
    st_nxt.done = 1'b0;
    st_nxt.rvalid = 1'b0;
    st_nxt.rd_pend = 1'b0;
    if (st_r.mode == MODE_NONE) begin
      // The mode is latched once after reset; a clocked capture keeps reset constant.
      st_nxt.mode = eeprom_mode_i ? MODE_EEPROM : (smbus_mode_i ? MODE_SMBUS : MODE_NONE);
    end
    case (st_r.load)
      LOAD_IDLE: begin
        if (load_start_i && st_r.mode == MODE_EEPROM) begin // [RULE7]
          st_nxt.load = LOAD_CHECK;
        end
      end
      LOAD_CHECK: begin
        if (load_valid_i) begin
          if (load_data_i == `SIGNATURE_MATCH && !load_last_i) begin // [RULE1]
            st_nxt.load = LOAD_RUN;
            st_nxt.load_addr = `OFS_VENDOR_ID_LOW;
          end else if (load_data_i == `SIGNATURE_MATCH) begin
            st_nxt.load = LOAD_IDLE;
            st_nxt.done = 1'b1;
          end else begin
            // Nothing is written on a mismatch, so the defaults stay in force.
            st_nxt.load = LOAD_IDLE; // [RULE1]
            st_nxt.abort = 1'b1;
          end
        end
      end
      LOAD_RUN: begin
        if (load_valid_i) begin
          wr_req = 1'b1;
          wr_addr = st_r.load_addr;
          st_nxt.load_addr = st_r.load_addr + 8'h01;
          if (load_last_i) begin
            st_nxt.load = LOAD_IDLE;
            st_nxt.done = 1'b1;
          end
        end
      end
      default: begin
        st_nxt.load = LOAD_IDLE;
      end
    endcase
    if (st_r.load == LOAD_IDLE && st_r.mode == MODE_SMBUS && host_wr_i) begin // [RULE7]
      wr_req = 1'b1;
      wr_addr = host_addr_i;
    end
    if (host_rd_i) begin
      st_nxt.rd_pend = 1'b1;
      st_nxt.rd_addr = host_addr_i;
    end
    if (st_r.rd_pend) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = read_byte;
    end
    st_nxt.vid = vid_now;
    st_nxt.pid_ss = pid_now; // [RULE5]
    st_nxt.pid_u2 = pid_now ^ `USB2_PID_XOR; // [RULE5]
  end

  assign is_id_addr = (wr_addr >= `OFS_VENDOR_ID_LOW) && (wr_addr <= `OFS_PRODUCT_ID_HIGH);
  assign regs.we = wr_req && !(otp_force && is_id_addr); // [RULE8]
  assign regs.waddr = wr_addr;
  assign regs.wdata = (st_r.load == LOAD_RUN) ? load_data_i : host_wdata_i;
  // The store is addressed from the request edge, so its registered byte belongs to this read
  // when the answer is built; an old address would return the byte of the previous read.
  assign regs.raddr = host_rd_i ? host_addr_i : st_r.rd_addr;

  // ID bytes are replaced by override values here.
  always_comb begin
    case (st_r.rd_addr)
      `OFS_EEPROM_SIGNATURE: read_byte = regs.rdata; // [RULE2]
      `OFS_VENDOR_ID_LOW: read_byte = vid_now[7:0]; // [RULE4]
      `OFS_VENDOR_ID_HIGH: read_byte = vid_now[15:8];
      `OFS_PRODUCT_ID_LOW: read_byte = pid_now[7:0];
      `OFS_PRODUCT_ID_HIGH: read_byte = pid_now[15:8];
      default: read_byte = `BYTE_ZERO;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= '{load: LOAD_IDLE, mode: MODE_NONE, load_addr: `BYTE_ZERO, abort: 1'b0,
                done: 1'b0, rd_pend: 1'b0, rd_addr: `BYTE_ZERO, rvalid: 1'b0,
                rdata: `BYTE_ZERO, vid: `ID_WORD_ZERO, pid_ss: `ID_WORD_ZERO,
                pid_u2: `ID_WORD_ZERO};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign load_busy_o = (st_r.load != LOAD_IDLE);
  assign load_abort_o = st_r.abort;
  assign load_done_o = st_r.done;
  assign host_rdata_o = st_r.rdata;
  assign host_rvalid_o = st_r.rvalid;
  assign vendor_id_o = st_r.vid;
  assign product_id_ss_o = st_r.pid_ss;
  assign product_id_usb2_o = st_r.pid_u2;
endmodule
`default_nettype wire

/* File: tb/id_config_register_bank_chk.sv */
// Concurrent assertions on the ports of the identity register bank.
`timescale 1ns/1ps
`default_nettype none
module id_cfg_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic load_start_i,
  input wire logic load_valid_i,
  input wire logic [7:0] load_data_i,
  input wire logic load_last_i,
  input wire logic load_busy_o,
  input wire logic load_abort_o,
  input wire logic load_done_o,
  input wire logic host_rd_i,
  input wire logic [7:0] host_addr_i,
  input wire logic [7:0] host_rdata_o,
  input wire logic host_rvalid_o,
  input wire logic [15:0] otp_vendor_id_i,
  input wire logic [15:0] otp_product_id_i,
  input wire logic [15:0] vendor_id_o,
  input wire logic [15:0] product_id_ss_o,
  input wire logic [15:0] product_id_usb2_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // High from a start strobe until the first loader byte arrives.
  logic first_r;
  wire ovr = (|otp_vendor_id_i) && (|otp_product_id_i);
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) first_r <= 1'b0;
    else first_r <= load_start_i || (first_r && !load_valid_i);
  end
  sequence s_bad_sig;
    first_r && load_valid_i && load_data_i != 8'h55;
  endsequence
  sequence s_abort_end;
    load_abort_o && !load_busy_o;
  endsequence
  chk_bad_sig: assert property (s_bad_sig |=> s_abort_end)
    else $error("bad signature did not abort the load");
  chk_good_sig: assert property (first_r && load_valid_i && load_data_i == 8'h55
    |=> !load_abort_o) else $error("good signature aborted");
  chk_load_done: assert property (!first_r && load_busy_o && load_valid_i && load_last_i
    |=> load_done_o && !load_busy_o) else $error("load did not finish on last byte");
  chk_rd_latency: assert property (host_rd_i |-> ##2 host_rvalid_o)
    else $error("read answer late");
  chk_rvalid_cause: assert property (host_rvalid_o |-> $past(host_rd_i, 2))
    else $error("read answer without request");
  chk_usb2_pid: assert property (!$past(rst_i)
    |-> product_id_usb2_o == (product_id_ss_o ^ 16'h0002)) else $error("usb2 id wrong");
  // The answer byte is captured one edge after the request, so it is held against the
  // override value of that edge; the host may change the override once the answer is out.
  chk_otp_read: assert property (host_rd_i && ovr && host_addr_i == 8'h03
    |-> ##2 host_rdata_o == $past(otp_product_id_i[7:0])) else $error("override read wrong");
  chk_otp_vid: assert property (ovr && !$past(rst_i, 2)
    && $past(otp_vendor_id_i, 2) == otp_vendor_id_i
    |-> vendor_id_o == otp_vendor_id_i) else $error("override vendor id wrong");
endmodule
bind id_config_register_bank id_cfg_chk u_chk (.*);
`default_nettype wire

/* File: tb/id_eeprom_model.sv */
// Loader byte source standing in for the attached serial memory.
`timescale 1ns/1ps
`default_nettype none
module id_eeprom_model (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [3:0] len_i,
  output logic valid_o,
  output logic [7:0] data_o,
  output logic last_o
);
  logic [7:0] mem [8];
  initial begin
    valid_o = 1'b0;
    data_o = 8'hC3;
    last_o = 1'b0;
    forever begin
      @(posedge clk_i);
      if (go_i) begin
        @(negedge clk_i);
        for (int i = 0; i < len_i; i++) begin
          @(negedge clk_i);
          valid_o = 1'b1;
          data_o = mem[i];
          last_o = (i == len_i - 1);
        end
        @(negedge clk_i);
        valid_o = 1'b0;
        last_o = 1'b0;
        // A released line must not keep showing the last byte.
        data_o = ~data_o;
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/id_config_register_bank_test.sv */
// Self-checking bench for the identity register bank.
`timescale 1ns/1ps
`default_nettype none
`define CMP(nm, e, g) begin \
  total_checks++; \
  if ((g) !== (e)) begin \
    n_mismatch++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); \
  end \
end
module id_config_register_bank_test;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ee_mode = 1'b1, sm_mode = 1'b0, go = 1'b0, wr = 1'b0, rd = 1'b0;
  logic saw_abort = 1'b0, saw_done = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00;
  logic [15:0] otp_v = 16'h0000, otp_p = 16'h0000;
  logic [3:0] len = 4'h0;
  logic vld, lst, busy, abrt, done, rvalid;
  logic [7:0] ldata, rdata;
  logic [15:0] vid, pid_ss, pid_u2;
  int n_mismatch = 0, total_checks = 0, cyc = 0;
  id_config_register_bank dut (.clk_i(clk_i), .rst_i(rst_i), .eeprom_mode_i(ee_mode),
    .smbus_mode_i(sm_mode), .otp_vendor_id_i(otp_v), .otp_product_id_i(otp_p),
    .load_start_i(go), .load_valid_i(vld), .load_data_i(ldata), .load_last_i(lst),
    .load_busy_o(busy), .load_abort_o(abrt), .load_done_o(done), .host_wr_i(wr),
    .host_rd_i(rd), .host_addr_i(addr), .host_wdata_i(wdata), .host_rdata_o(rdata),
    .host_rvalid_o(rvalid), .vendor_id_o(vid), .product_id_ss_o(pid_ss),
    .product_id_usb2_o(pid_u2));
  id_eeprom_model em (.clk_i(clk_i), .go_i(go), .len_i(len), .valid_o(vld),
    .data_o(ldata), .last_o(lst));
  initial forever #10 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    saw_abort = saw_abort | abrt;
    saw_done = saw_done | done;
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      conclude();
    end
  end
  task automatic conclude();
    if (n_mismatch == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk_i);
    wr = 1'b0;
    repeat (2) @(negedge clk_i);
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_i);
    rd = 1'b1;
    addr = a;
    @(negedge clk_i);
    rd = 1'b0;
    for (int k = 0; k < 3 && rvalid !== 1'b1; k++) @(negedge clk_i);
    `CMP("rvalid", 1'b1, rvalid)
    `CMP("rdata", e, rdata)
  endtask
  task automatic load(input int n);
    @(negedge clk_i);
    saw_abort = 1'b0;
    saw_done = 1'b0;
    len = n[3:0];
    go = 1'b1;
    @(negedge clk_i);
    go = 1'b0;
    repeat (n + 4) @(negedge clk_i);
  endtask
  initial begin
    repeat (8) @(negedge clk_i);
    rst_i = 1'b0;
    repeat (2) @(negedge clk_i);
    rd_reg(8'h00, 8'h00);
    `CMP("pid_u2", 16'h0003, pid_u2)
    wr_reg(8'h01, 8'h77);
    rd_reg(8'h01, 8'h01);
    em.mem = '{8'hAA, 8'h34, 8'h12, 8'h78, 8'h56, 8'h00, 8'h00, 8'h00};
    load(3);
    `CMP("abort", 1'b1, saw_abort)
    rd_reg(8'h01, 8'h01);
    em.mem[0] = 8'h55;
    load(5);
    `CMP("done", 1'b1, saw_done)
    `CMP("vid", 16'h1234, vid)
    `CMP("pid_u2", 16'h567A, pid_u2)
    `CMP("pid_ss", 16'h5678, pid_ss)
    rst_i = 1'b1;
    ee_mode = 1'b0;
    sm_mode = 1'b1;
    repeat (8) @(negedge clk_i);
    rst_i = 1'b0;
    repeat (2) @(negedge clk_i);
    rd_reg(8'h03, 8'h01);
    for (int i = 0; i < 5; i++) wr_reg(i[7:0], 8'hA0 + i[7:0]);
    for (int i = 0; i < 5; i++) rd_reg(i[7:0], 8'hA0 + i[7:0]);
    `CMP("vid", 16'hA2A1, vid)
    `CMP("pid_u2", 16'hA4A1, pid_u2)
    rd_reg(8'h05, 8'h00);
    otp_v = 16'hBEEF;
    otp_p = 16'h1357;
    wr_reg(8'h03, 8'h11);
    rd_reg(8'h03, 8'h57);
    `CMP("vid", 16'hBEEF, vid)
    otp_p = 16'h0000;
    rd_reg(8'h03, 8'hA3);
    conclude();
  end
endmodule
`default_nettype wire
